// ==== core/lvs_defs.svh ====
`ifndef LVS_DEFS_SVH
`define LVS_DEFS_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define LVS_OFF_CTRL      4'h0
`define LVS_OFF_SETPOINT  4'h4
`define LVS_OFF_COMP      4'h8
`define LVS_OFF_STATUS    4'hC
`define LVS_ADDR_W        4

// ****************************************************************
// Control register fields
// ****************************************************************
`define LVS_CTRL_PUMP_EN   0
`define LVS_CTRL_MULT_LO   1
`define LVS_CTRL_MULT_HI   3
`define LVS_CTRL_COMP_EN   4
`define LVS_CTRL_MEAS_EN   5
`define LVS_CTRL_FILT_EN   6
`define LVS_CTRL_W         7

// ****************************************************************
// Compensation register fields
// ****************************************************************
`define LVS_COMP_T1_LO     0
`define LVS_COMP_T2_LO     3
`define LVS_COMP_T3_LO     6
`define LVS_COMP_T4_LO     9
`define LVS_COMP_SLOPE_LO  12
`define LVS_COMP_SLOPE_HI  15
`define LVS_COMP_W         16

// ****************************************************************
// Reset values
// ****************************************************************
`define LVS_RST_CTRL       7'h00
`define LVS_RST_SETPOINT   9'h000
`define LVS_RST_COMP       16'h0000
`define LVS_RST_READING    8'hFF

// ****************************************************************
// Voltage law, in millivolts
// ****************************************************************
`define LVS_OFFSET_MV      3990
`define LVS_STEP_MV        30
`define LVS_CEILING_MV     12000
`define LVS_MAX_CODE       ((`LVS_CEILING_MV - `LVS_OFFSET_MV) / `LVS_STEP_MV)
`define LVS_ZERO_READING   96

// ****************************************************************
// Timing
// ****************************************************************
`define LVS_CLK_KHZ        100000
`define LVS_CONV_MS        8
`define LVS_PERIOD_MS      1000
`define LVS_CONV_CYCLES    (`LVS_CONV_MS * `LVS_CLK_KHZ)
`define LVS_PERIOD_CYCLES  (`LVS_PERIOD_MS * `LVS_CLK_KHZ)

`endif

// ==== core/lvs_pkg.sv ====
`default_nettype none

package lvs_pkg;

  // ****************************************************************
  // Measurement sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    LVS_IDLE,
    LVS_CONVERT,
    LVS_WAIT
  } lvs_meas_state_type;

endpackage

`default_nettype wire

// ==== core/lvs_filter.sv ====
`include "lvs_defs.svh"
`default_nettype none

module lvs_filter
  import lvs_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       load_i,
  input  wire logic       filter_en_i,
  input  wire logic [7:0] sample_i,
  output logic      [7:0] reading_o
);

  logic [7:0] reading_reg;
  logic [7:0] reading_next;
  logic [9:0] blend;

  // ****************************************************************
  // Smoothing: three quarters old value, one quarter new sample
  // ****************************************************************
  always_comb
  begin
    blend = {2'b00, reading_reg} + {2'b00, reading_reg} + {2'b00, reading_reg}
          + {2'b00, sample_i} + 10'h002;
    if (!filter_en_i || reading_reg == `LVS_RST_READING)
    begin
      reading_next = sample_i;
    end
    else
    begin
      reading_next = blend[9:2];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      reading_reg <= `LVS_RST_READING;
    end
    else if (load_i)
    begin
      reading_reg <= reading_next;
    end
  end

  assign reading_o = reading_reg;

endmodule // lvs_filter

`default_nettype wire

// ==== core/lvs_top.sv ====
`include "lvs_defs.svh"
`default_nettype none

module lvs_top
  import lvs_pkg::*;
#(
  parameter int unsigned CONV_CYCLES   = `LVS_CONV_CYCLES,
  parameter int unsigned PERIOD_CYCLES = `LVS_PERIOD_CYCLES
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [7:0]  sensor_value_i,
  output logic             sensor_run_o,
  output logic             pump_enable_o,
  output logic      [2:0]  pump_multiplier_sel_o,
  output logic             drive_ext_sel_o,
  output logic      [8:0]  drive_code_o
);

  localparam logic [10:0] MAX_CODE = 11'(`LVS_MAX_CODE);
  localparam logic [8:0]  ZERO_RD  = 9'(`LVS_ZERO_READING);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [`LVS_CTRL_W-1:0] ctrl_reg;
  logic [8:0]             setpoint_reg;
  logic [`LVS_COMP_W-1:0] comp_reg;
  logic [31:0]            wb_dat_reg;
  logic                   wb_ack_reg;
  logic                   sensor_run_reg;
  logic                   pump_en_reg;
  logic [2:0]             pump_mult_reg;
  logic                   ext_sel_reg;
  logic [8:0]             drive_code_reg;
  logic [8:0]             drive_code_next;
  logic                   capped_reg;
  logic                   capped_next;
  lvs_meas_state_type     state_reg;
  lvs_meas_state_type     state_next;
  logic [31:0]            count_reg;
  logic [31:0]            count_next;
  logic                   load_sample;
  logic [7:0]             temp_reading;
  logic                   wb_req;
  logic                   wb_wr;
  logic [3:0]             reg_sel;
  logic [31:0]            wmask;
  logic [31:0]            rd_data;
  logic                   pump_enable;
  logic                   temp_comp_enable;
  logic                   temp_measure_enable;
  logic                   temp_filter_enable;
  logic [2:0]             lim1;
  logic [2:0]             lim2;
  logic [2:0]             lim3;
  logic [2:0]             lim4;
  logic                   limits_ok;
  logic signed [3:0]      slope;
  logic signed [8:0]      temp_delta;
  logic signed [12:0]     comp_prod;
  logic signed [9:0]      comp_scaled;
  logic signed [8:0]      temp_comp_term;
  logic signed [10:0]     code_sum;

  assign pump_enable         = ctrl_reg[`LVS_CTRL_PUMP_EN];
  assign temp_comp_enable    = ctrl_reg[`LVS_CTRL_COMP_EN];
  assign temp_measure_enable = ctrl_reg[`LVS_CTRL_MEAS_EN];
  assign temp_filter_enable  = ctrl_reg[`LVS_CTRL_FILT_EN];
  assign lim1  = comp_reg[`LVS_COMP_T1_LO +: 3];
  assign lim2  = comp_reg[`LVS_COMP_T2_LO +: 3];
  assign lim3  = comp_reg[`LVS_COMP_T3_LO +: 3];
  assign lim4  = comp_reg[`LVS_COMP_T4_LO +: 3];
  assign slope = comp_reg[`LVS_COMP_SLOPE_HI:`LVS_COMP_SLOPE_LO];

  // ****************************************************************
  // Wishbone decode
  // ****************************************************************
  assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_reg;
  assign wb_wr   = wb_req && wb_we_i;
  assign reg_sel = wb_adr_i[`LVS_ADDR_W-1:0];
  assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_reg <= 1'b0;
    end
    else
    begin
      wb_ack_reg <= wb_req;
    end
  end

  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (wb_adr_i[31:`LVS_ADDR_W] == '0)
    begin
      case (reg_sel)
        `LVS_OFF_CTRL:     rd_data[`LVS_CTRL_W-1:0] = ctrl_reg;
        `LVS_OFF_SETPOINT: rd_data[8:0] = setpoint_reg;
        `LVS_OFF_COMP:     rd_data[`LVS_COMP_W-1:0] = comp_reg;
        `LVS_OFF_STATUS:   rd_data = {12'h000, capped_reg, drive_code_reg,
                                      1'b0, sensor_run_reg, temp_reading};
        default:           rd_data = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_dat_reg <= 32'h0000_0000;
    end
    else if (wb_req && !wb_we_i)
    begin
      wb_dat_reg <= rd_data;
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_reg <= `LVS_RST_CTRL;
    end
    else if (wb_wr && wb_adr_i[31:`LVS_ADDR_W] == '0 && reg_sel == `LVS_OFF_CTRL)
    begin
      ctrl_reg <= (ctrl_reg & ~wmask[`LVS_CTRL_W-1:0])
                | (wb_dat_i[`LVS_CTRL_W-1:0] & wmask[`LVS_CTRL_W-1:0]);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      setpoint_reg <= `LVS_RST_SETPOINT;
    end
    else if (wb_wr && wb_adr_i[31:`LVS_ADDR_W] == '0 && reg_sel == `LVS_OFF_SETPOINT)
    begin
      setpoint_reg <= (setpoint_reg & ~wmask[8:0]) | (wb_dat_i[8:0] & wmask[8:0]);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      comp_reg <= `LVS_RST_COMP;
    end
    else if (wb_wr && wb_adr_i[31:`LVS_ADDR_W] == '0 && reg_sel == `LVS_OFF_COMP)
    begin
      comp_reg <= (comp_reg & ~wmask[`LVS_COMP_W-1:0])
                | (wb_dat_i[`LVS_COMP_W-1:0] & wmask[`LVS_COMP_W-1:0]);
    end
  end

  // ****************************************************************
  // Temperature measurement sequencer
  // ****************************************************************
  always_comb
  begin
    state_next  = state_reg;
    count_next  = count_reg;
    load_sample = 1'b0;
    case (state_reg)
      LVS_IDLE:
      begin
        count_next = 32'h0000_0000;
        if (temp_measure_enable)
        begin
          state_next = LVS_CONVERT;
        end
      end
      LVS_CONVERT:
      begin
        count_next = count_reg + 32'h0000_0001;
        if (count_reg == CONV_CYCLES - 1)
        begin
          load_sample = 1'b1;
          state_next  = LVS_WAIT;
        end
      end
      LVS_WAIT:
      begin
        count_next = count_reg + 32'h0000_0001;
        if (count_reg == PERIOD_CYCLES - 1)
        begin
          count_next = 32'h0000_0000;
          state_next = LVS_CONVERT;
        end
      end
      default:
      begin
        state_next = LVS_IDLE;
        count_next = 32'h0000_0000;
      end
    endcase
    if (!temp_measure_enable)
    begin
      state_next  = LVS_IDLE;
      count_next  = 32'h0000_0000;
      load_sample = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= LVS_IDLE;
      count_reg <= 32'h0000_0000;
    end
    else
    begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sensor_run_reg <= 1'b0;
    end
    else
    begin
      sensor_run_reg <= (state_next == LVS_CONVERT);
    end
  end

  lvs_filter u_filter (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .load_i      (load_sample),
    .filter_en_i (temp_filter_enable),
    .sample_i    (sensor_value_i),
    .reading_o   (temp_reading)
  );

  // ****************************************************************
  // Compensation term and drive code
  // ****************************************************************
  // Limit ordering check
  assign limits_ok = (lim1 < lim2) && (lim3 < lim4);

  always_comb
  begin
    temp_delta  = $signed({1'b0, temp_reading}) - $signed(ZERO_RD);
    comp_prod   = 13'(temp_delta * slope);
    comp_scaled = 10'(comp_prod >>> 3);
    if (comp_scaled > 10'sd255)
    begin
      temp_comp_term = 9'sd255;
    end
    else if (comp_scaled < -10'sd256)
    begin
      temp_comp_term = 9'sh100;
    end
    else
    begin
      temp_comp_term = comp_scaled[8:0];
    end
    if (!pump_enable || !temp_comp_enable || !limits_ok
        || temp_reading == `LVS_RST_READING)
    begin
      temp_comp_term = 9'sd0;
    end
    code_sum = $signed({2'b00, setpoint_reg}) + 11'(temp_comp_term);
    capped_next = 1'b0;
    if (code_sum < 11'sd0)
    begin
      drive_code_next = 9'h000;
    end
    else if (code_sum > $signed(MAX_CODE))
    begin
      drive_code_next = MAX_CODE[8:0];
      capped_next     = 1'b1;
    end
    else
    begin
      drive_code_next = code_sum[8:0];
    end
    if (!pump_enable)
    begin
      drive_code_next = 9'h000;
      capped_next     = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      drive_code_reg <= 9'h000;
      capped_reg     <= 1'b0;
    end
    else
    begin
      drive_code_reg <= drive_code_next;
      capped_reg     <= capped_next;
    end
  end

  // ****************************************************************
  // Supply selection and pump control
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pump_en_reg   <= 1'b0;
      pump_mult_reg <= 3'h0;
      ext_sel_reg   <= 1'b1;
    end
    else
    begin
      pump_en_reg   <= pump_enable;
      ext_sel_reg   <= !pump_enable;
      pump_mult_reg <= ctrl_reg[`LVS_CTRL_MULT_HI:`LVS_CTRL_MULT_LO];
    end
  end

  assign wb_dat_o              = wb_dat_reg;
  assign wb_ack_o              = wb_ack_reg;
  assign sensor_run_o          = sensor_run_reg;
  assign pump_enable_o         = pump_en_reg;
  assign pump_multiplier_sel_o = pump_mult_reg;
  assign drive_ext_sel_o       = ext_sel_reg;
  assign drive_code_o          = drive_code_reg;

endmodule // lvs_top

`default_nettype wire

// ==== dv/lvs_checker.sv ====
`default_nettype none

module lvs_checker
#(
  parameter int unsigned CONV_CYCLES   = 20,
  parameter int unsigned PERIOD_CYCLES = 100
)
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [7:0]  sensor_value_i,
  input wire logic        sensor_run_o,
  input wire logic        pump_enable_o,
  input wire logic [2:0]  pump_multiplier_sel_o,
  input wire logic        drive_ext_sel_o,
  input wire logic [8:0]  drive_code_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Run length counter
  // ****
  logic [31:0] run_cnt_reg;
  logic [31:0] run_cnt_next;

  assign run_cnt_next = sensor_run_o ? run_cnt_reg + 32'h0000_0001 : 32'h0000_0000;

  always_ff @(posedge clk_i)
    if (rst_i)
      run_cnt_reg <= 32'h0000_0000;
    else
      run_cnt_reg <= run_cnt_next;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence s_ctrl_wr;
    s_taken ##0 (wb_we_i && wb_adr_i == 32'h0000_0000 && wb_sel_i[0]);
  endsequence

  property p_ack_resp;
    s_taken |=> wb_ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp)
    else $error("no ack one cycle after request");

  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");

  property p_ext_code;
    drive_ext_sel_o |-> drive_code_o == 9'h000;
  endproperty
  a_ext_code: assert property (p_ext_code)
    else $error("drive code nonzero with external supply");

  property p_ext_pump;
    pump_enable_o != drive_ext_sel_o;
  endproperty
  a_ext_pump: assert property (p_ext_pump)
    else $error("pump and external select disagree");

  property p_cap;
    drive_code_o <= 9'h10B;
  endproperty
  a_cap: assert property (p_cap)
    else $error("drive code above ceiling");

  property p_run_len;
    run_cnt_reg <= CONV_CYCLES;
  endproperty
  a_run_len: assert property (p_run_len)
    else $error("conversion runs too long");

  property p_mult;
    s_ctrl_wr |-> ##2 (pump_multiplier_sel_o == $past(wb_dat_i[3:1], 2));
  endproperty
  a_mult: assert property (p_mult)
    else $error("multiplier does not follow write");

  property p_pump_wr;
    s_ctrl_wr |-> ##2 (pump_enable_o == $past(wb_dat_i[0], 2));
  endproperty
  a_pump_wr: assert property (p_pump_wr)
    else $error("pump enable does not follow write");

  property p_reset;
    $past(rst_i) |-> drive_ext_sel_o && !pump_enable_o && !sensor_run_o;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs not in reset state");

endmodule // lvs_checker

bind lvs_top lvs_checker #(
  .CONV_CYCLES   (CONV_CYCLES),
  .PERIOD_CYCLES (PERIOD_CYCLES)
) i_chk (.*);

`default_nettype wire

// ==== dv/lvs_sensor_model.sv ====
`default_nettype none

module lvs_sensor_model
(
  input  wire logic       clk_i,
  input  wire logic       run_i,
  input  wire logic [7:0] level_i,
  output logic      [7:0] sensor_value_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       run_d_reg = 1'b0;
  logic [7:0] junk_reg  = 8'h00;

  always_ff @(posedge clk_i)
    run_d_reg <= run_i;

  always_ff @(posedge clk_i)
    junk_reg <= junk_reg + 8'h35;

  // Valid only during conversion and one cycle after
  assign sensor_value_o = (run_i || run_d_reg) ? level_i : (~level_i ^ junk_reg);
endmodule // lvs_sensor_model

`default_nettype wire

// ==== dv/testbench.sv ====
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CONV = 20;
  localparam int PER  = 100;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [3:0]  sel   = 4'hF;
  logic [31:0] adr   = 32'h0000_0000;
  logic [31:0] dat   = 32'h0000_0000;
  logic [31:0] dat_o;
  logic        ack;
  logic [7:0]  sval;
  logic [7:0]  level = 8'h00;
  logic        run;
  logic        run_q = 1'b0;
  logic        pump;
  logic        ext;
  logic [2:0]  mult;
  logic [8:0]  code;
  logic [31:0] seed  = 32'h0000_E10B;
  int          n_fail = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          tick = 0;
  int          last_rise = 0;
  int          period = 0;

  lvs_top #(.CONV_CYCLES(CONV), .PERIOD_CYCLES(PER)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .sensor_value_i(sval), .sensor_run_o(run), .pump_enable_o(pump),
    .pump_multiplier_sel_o(mult), .drive_ext_sel_o(ext), .drive_code_o(code));

  lvs_sensor_model i_sensor (.clk_i(clk_i), .run_i(run), .level_i(level),
    .sensor_value_o(sval));

  initial
    forever #5 clk_i = ~clk_i;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [9:0] exp_drv(input logic pm, input logic ce,
      input logic [7:0] rd, input logic [8:0] sp, input logic [15:0] cw);
    int t;
    t = 0;
    if (ce && rd != 8'hFF && cw[2:0] < cw[5:3] && cw[8:6] < cw[11:9])
      t = ((int'(rd) - 96) * int'($signed(cw[15:12]))) >>> 3;
    t = (t > 255) ? 255 : (t < -256) ? -256 : t;
    t = t + int'(sp);
    t = (t < 0) ? 0 : t;
    if (!pm)
      return 10'h000;
    return (t > 267) ? 10'h30B : 10'(t);
  endfunction

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= 32'(a);
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wait_lvl(input logic v, output int n);
    n = 0;
    while (run !== v && n < 1000)
    begin
      @(negedge clk_i);
      n++;
    end
  endtask

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      final_report();
    end
  end

  always @(negedge clk_i)
  begin
    tick++;
    if (run === 1'b1 && !run_q)
    begin
      period = tick - last_rise;
      last_rise = tick;
    end
    run_q = run;
  end

  initial
  begin
    logic [31:0] r;
    logic [31:0] x;
    logic [15:0] cw;
    logic [9:0]  e;
    logic [7:0]  lv;
    logic [7:0]  rd;
    logic        ce;
    logic        pm;
    int          n;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 12'h000, 32'h0000_0000, r);
    chk(r, 32'h0000_0000);
    wb(1'b0, 12'h00C, 32'h0000_0000, r);
    chk(32'(r[7:0]), 32'h0000_00FF);
    chk(32'({pump, ext, run}), 32'h0000_0002);
    wb(1'b1, 12'h100, 32'h0000_0001, r);
    wb(1'b1, 12'h00C, 32'h0000_0000, r);
    wb(1'b0, 12'h00C, 32'h0000_0000, r);
    chk(32'(r[7:0]), 32'h0000_00FF);
    wb(1'b0, 12'h100, 32'h0000_0000, r);
    chk(r, 32'h0000_0000);
    chk(32'(ext), 32'h0000_0001);
    $display("test reset and map done");
    wb(1'b1, 12'h008, 32'h0000_8208, r);
    wb(1'b1, 12'h000, 32'h0000_0010, r);
    for (int i = 0; i < 4; i++)
    begin
      x = xs();
      wb(1'b1, 12'h004, x, r);
      wb(1'b0, 12'h004, 32'h0000_0000, r);
      chk(r, 32'(x[8:0]));
      chk(32'({ext, code}), 32'h0000_0200);
    end
    $display("test external supply done");
    for (int m = 0; m < 8; m++)
    begin
      wb(1'b1, 12'h000, 32'({m[2:0], 1'b1}), r);
      chk(32'({pump, ext, mult}), 32'({2'b10, m[2:0]}));
    end
    sel <= 4'hE;
    wb(1'b1, 12'h000, 32'h0000_0000, r);
    sel <= 4'hF;
    chk(32'(pump), 32'h0000_0001);
    $display("test pump control done");
    wb(1'b1, 12'h000, 32'h0000_0011, r);
    for (int i = 0; i < 8; i++)
    begin
      x = (i == 0) ? 32'h0000_0000 : (i == 1) ? 32'h0000_010B : (i == 2) ? 32'h0000_010C :
          (i == 3) ? 32'h0000_01FF : xs();
      wb(1'b1, 12'h004, x, r);
      e = exp_drv(1'b1, 1'b1, 8'hFF, x[8:0], 16'h8208);
      wb(1'b0, 12'h00C, 32'h0000_0000, r);
      chk(32'(r[19:10]), 32'(e));
      chk(32'(code), 32'(e[8:0]));
    end
    $display("test setpoint law done");
    x = xs();
    lv = 8'd100 + 8'(x[4:0]);
    level <= lv;
    wb(1'b1, 12'h000, 32'h0000_0021, r);
    wait_lvl(1'b1, n);
    wait_lvl(1'b0, n);
    chk(32'(n), 32'(CONV));
    wb(1'b0, 12'h00C, 32'h0000_0000, r);
    chk(32'(r[7:0]), 32'(lv));
    x = xs();
    rd = 8'd100 + 8'(x[4:0]);
    level <= rd;
    wb(1'b1, 12'h000, 32'h0000_0061, r);
    wait_lvl(1'b1, n);
    @(posedge clk_i);
    chk(32'(period), 32'(PER));
    wait_lvl(1'b0, n);
    rd = 8'((3 * int'(lv) + int'(rd) + 2) >> 2);
    wb(1'b0, 12'h00C, 32'h0000_0000, r);
    chk(32'(r[7:0]), 32'(rd));
    wb(1'b1, 12'h000, 32'h0000_0001, r);
    $display("test measurement done");
    for (int i = 0; i < 10; i++)
    begin
      x = xs();
      cw = (i == 0) ? 16'h8208 : (i == 1) ? 16'h7000 : x[31:16];
      ce = (i < 3) ? 1'b1 : x[9];
      pm = (i == 2) ? 1'b0 : 1'b1;
      x = (i == 0) ? 32'h0000_0000 : x;
      wb(1'b1, 12'h008, 32'(cw), r);
      wb(1'b1, 12'h004, x, r);
      wb(1'b1, 12'h000, 32'({ce, 3'b000, pm}), r);
      e = exp_drv(pm, ce, rd, x[8:0], cw);
      chk(32'(code), 32'(e[8:0]));
    end
    $display("test compensation done");
    final_report();
  end
endmodule // testbench

`default_nettype wire
